// *** flash_pin_device.sv ***
// Device end of the serial flash pin interface.
// Link logic runs on the host serial clock; user logic on clk_sys_i.
`timescale 1ns/100ps

module flash_pin_device
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    flash_pin_if.device                   link,
    input  wire logic                     busy_i,
    input  wire logic                     quad_enable_bit_i,
    input  wire logic                     status_protect_bit_hi_i,
    input  wire logic                     status_protect_bit_lo_i,
    input  wire logic                     tx_valid_i,
    input  wire logic [7:0]               tx_data_i,
    input  wire flash_pin_pkg::lane_mode_t tx_mode_i,
    output logic                          tx_ready_o,
    output logic                          rx_valid_o,
    output logic [7:0]                    rx_data_o,
    output logic                          selected_o,
    output logic                          power_active_o,
    output logic                          cmd_enabled_o,
    output logic                          status_write_ok_o
);
    import flash_pin_pkg::*;

    // ************************************************
    // System domain
    // ************************************************
    logic       cs_meta_q, cs_sync_q, cs_prev_q, cs_seen_q;
    logic       wp_meta_q, wp_sync_q;
    logic       rx_meta_q, rx_sync_q, rx_prev_q;
    logic       ack_meta_q, ack_sync_q;
    logic       req_tgl_q;
    logic [7:0] tx_word_q;
    lane_mode_t tx_mode_q;

    // Link domain signals read here
    logic       rx_tgl_q;
    logic [7:0] rx_byte_q;
    logic       ack_tgl_q;

    // Chain resets low so a select held low at reset is no edge
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_meta_q <= 1'b0;
            cs_sync_q <= 1'b0;
            cs_prev_q <= 1'b0;
        end
        else
        begin
            cs_meta_q <= link.cs_n;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cs_seen_q      <= 1'b0;
            selected_o     <= 1'b0;
            power_active_o <= 1'b0;
            cmd_enabled_o  <= 1'b0;
        end
        else
        begin
            if (cs_prev_q && !cs_sync_q)
            begin
                cs_seen_q <= 1'b1;
            end
            selected_o     <= !cs_sync_q;
            power_active_o <= !cs_sync_q || busy_i;
            cmd_enabled_o  <= cs_seen_q;
        end
    end

    // Status lock from write-protect pin
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_meta_q         <= 1'b1;
            wp_sync_q         <= 1'b1;
            status_write_ok_o <= 1'b1;
        end
        else
        begin
            wp_meta_q <= link.io[2];
            wp_sync_q <= wp_meta_q;
            status_write_ok_o <= quad_enable_bit_i
                || ({status_protect_bit_hi_i, status_protect_bit_lo_i} != SP_PIN_LOCK)
                || wp_sync_q;
        end
    end

    // Received bytes handed over by toggle
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_meta_q  <= 1'b0;
            rx_sync_q  <= 1'b0;
            rx_prev_q  <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= BYTE_RST;
        end
        else
        begin
            rx_meta_q  <= rx_tgl_q;
            rx_sync_q  <= rx_meta_q;
            rx_prev_q  <= rx_sync_q;
            rx_valid_o <= (rx_sync_q != rx_prev_q) && cs_seen_q;
            if (rx_sync_q != rx_prev_q)
            begin
                rx_data_o <= rx_byte_q;
            end
        end
    end

    // Transmit word handshake toward the link
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
            req_tgl_q  <= 1'b0;
            tx_ready_o <= 1'b0;
            tx_word_q  <= BYTE_RST;
            tx_mode_q  <= LANE_SINGLE;
        end
        else
        begin
            ack_meta_q <= ack_tgl_q;
            ack_sync_q <= ack_meta_q;
            if (tx_valid_i && tx_ready_o)
            begin
                tx_word_q  <= tx_data_i;
                tx_mode_q  <= tx_mode_i;
                req_tgl_q  <= !req_tgl_q;
                tx_ready_o <= 1'b0;
            end
            else
            begin
                tx_ready_o <= (ack_sync_q == req_tgl_q);
            end
        end
    end

    // ************************************************
    // Link domain
    // ************************************************
    logic       frame_rst;
    logic       qe_meta_q, qe_sync_q;
    logic       paused;
    logic [2:0] in_cnt_q;
    logic [6:0] in_sh_q;
    logic       in_en;
    logic       req_meta_q, req_sync_q;
    logic       out_act_q;
    lane_mode_t out_mode_q;
    logic [7:0] out_sh_q;
    logic [2:0] out_left_q;
    logic       load;
    lane_mode_t mode_n;
    logic [7:0] sh_n;
    logic [3:0] lanes_n;
    logic [3:0] oe_n;
    logic [3:0] io_q;
    logic [3:0] oe_q;

    // Deselect clears all frame state at once
    assign frame_rst = rst_i || link.cs_n;
    assign paused    = !qe_sync_q && !link.io[3] && !link.cs_n;
    assign in_en     = !paused && !(out_act_q && out_mode_q != LANE_SINGLE);

    always_ff @(posedge link.sck or posedge rst_i)
    begin
        if (rst_i)
        begin
            qe_meta_q <= 1'b0;
            qe_sync_q <= 1'b0;
        end
        else
        begin
            qe_meta_q <= quad_enable_bit_i;
            qe_sync_q <= qe_meta_q;
        end
    end

    always_ff @(posedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            in_cnt_q <= 3'h0;
            in_sh_q  <= 7'h00;
        end
        else if (in_en)
        begin
            in_cnt_q <= in_cnt_q + 3'h1;
            in_sh_q  <= {in_sh_q[5:0], link.io[0]};
        end
    end

    always_ff @(posedge link.sck or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_tgl_q  <= 1'b0;
            rx_byte_q <= BYTE_RST;
        end
        else if (in_en && !link.cs_n && in_cnt_q == BIT_LAST)
        begin
            rx_byte_q <= {in_sh_q, link.io[0]};
            rx_tgl_q  <= !rx_tgl_q;
        end
    end

    // Next launch values for the falling edge
    always_comb
    begin
        // Launch only on a byte boundary of the input stream
        load    = !paused && out_left_q == 3'h0 && in_cnt_q == 3'h0 && req_sync_q != ack_tgl_q;
        mode_n  = load ? tx_mode_q : out_mode_q;
        if (mode_n == LANE_QUAD && !qe_sync_q)
        begin
            mode_n = LANE_SINGLE;
        end
        sh_n    = load ? tx_word_q : out_sh_q;
        lanes_n = LANES_RST;
        oe_n    = LANES_RST;
        if (!load && out_left_q != 3'h0)
        begin
            case (mode_n)
                LANE_DUAL: sh_n = {out_sh_q[5:0], 2'b00};
                LANE_QUAD: sh_n = {out_sh_q[3:0], 4'h0};
                default:   sh_n = {out_sh_q[6:0], 1'b0};
            endcase
        end
        case (mode_n)
            LANE_DUAL:
            begin
                lanes_n = {2'b00, sh_n[7:6]};
                oe_n    = 4'b0011;
            end
            LANE_QUAD:
            begin
                lanes_n = sh_n[7:4];
                oe_n    = 4'b1111;
            end
            default:
            begin
                lanes_n = {2'b00, sh_n[7], 1'b0};
                oe_n    = 4'b0010;
            end
        endcase
    end

    always_ff @(negedge link.sck or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
        end
        else
        begin
            req_meta_q <= req_tgl_q;
            req_sync_q <= req_meta_q;
            if (load && !link.cs_n)
            begin
                ack_tgl_q <= !ack_tgl_q;
            end
        end
    end

    always_ff @(negedge link.sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            out_act_q  <= 1'b0;
            out_mode_q <= LANE_SINGLE;
            out_sh_q   <= BYTE_RST;
            out_left_q <= 3'h0;
            io_q       <= LANES_RST;
            oe_q       <= LANES_RST;
        end
        else if (!paused)
        begin
            out_mode_q <= mode_n;
            out_sh_q   <= sh_n;
            if (load)
            begin
                out_act_q  <= 1'b1;
                out_left_q <= (mode_n == LANE_QUAD) ? 3'h1 : (mode_n == LANE_DUAL) ? 3'h3 : 3'h7;
                io_q       <= lanes_n;
                oe_q       <= oe_n;
            end
            else if (out_left_q != 3'h0)
            begin
                out_left_q <= out_left_q - 3'h1;
                io_q       <= lanes_n;
            end
            else
            begin
                out_act_q <= 1'b0;
                oe_q      <= LANES_RST;
            end
        end
    end

    assign link.dev_io_o  = io_q;
    assign link.dev_io_oe = oe_q;

endmodule

// *** flash_pin_host.sv ***
// Host controller end of the serial flash pin interface.
// Makes the serial clock from clk_sys_i by a divider, mode 0.
`timescale 1ns/100ps
module flash_pin_host
(
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    flash_pin_if.host                     link,
    input  wire logic                     quad_enable_bit_i,
    input  wire logic                     wp_level_i,
    input  wire logic                     hold_i,
    input  wire logic                     xfer_valid_i,
    input  wire logic [7:0]               xfer_data_i,
    input  wire logic                     xfer_read_i,
    input  wire flash_pin_pkg::lane_mode_t xfer_mode_i,
    input  wire logic                     xfer_last_i,
    output logic                          xfer_ready_o,
    output logic                          rx_valid_o,
    output logic [7:0]                    rx_data_o,
    output logic                          busy_o
);
    import flash_pin_pkg::*;

    host_state_t state_q;
    logic [2:0]  div_q;
    logic [2:0]  left_q;
    logic [7:0]  sh_q;
    logic        read_q;
    logic        last_q;
    lane_mode_t  mode_q;
    logic        hold_q;
    logic        cs_n_q;
    logic        sck_q;
    logic [3:0]  io_meta_q, io_sync_q;
    logic        take;
    logic        half_end;

    assign take     = xfer_valid_i && xfer_ready_o;
    assign half_end = (div_q == HALF_LAST);

    // ************************************************
    // Pin synchroniser
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            io_meta_q <= LANES_RST;
            io_sync_q <= LANES_RST;
        end
        else
        begin
            io_meta_q <= link.io;
            io_sync_q <= io_meta_q;
        end
    end

    // ************************************************
    // Sequencer
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q    <= H_IDLE;
            div_q      <= 3'h0;
            left_q     <= 3'h0;
            sh_q       <= BYTE_RST;
            read_q     <= 1'b0;
            last_q     <= 1'b0;
            mode_q     <= LANE_SINGLE;
            hold_q     <= 1'b0;
            cs_n_q     <= 1'b1;
            sck_q      <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= BYTE_RST;
        end
        else
        begin
            rx_valid_o <= 1'b0;
            div_q      <= half_end ? 3'h0 : div_q + 3'h1;
            if (take)
            begin
                sh_q   <= xfer_data_i;
                read_q <= xfer_read_i;
                last_q <= xfer_last_i;
                mode_q <= xfer_read_i ? xfer_mode_i : LANE_SINGLE;
                left_q <= (xfer_read_i && xfer_mode_i == LANE_QUAD) ? 3'h1
                        : (xfer_read_i && xfer_mode_i == LANE_DUAL) ? 3'h3 : 3'h7;
                div_q  <= 3'h0;
            end
            case (state_q)
                H_IDLE:
                begin
                    if (take)
                    begin
                        cs_n_q  <= 1'b0;
                        state_q <= H_LEAD;
                    end
                end
                H_LEAD:
                begin
                    if (half_end)
                    begin
                        state_q <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (hold_q)
                    begin
                        hold_q <= hold_i;
                        div_q  <= 3'h0;
                    end
                    else if (half_end && hold_i && !quad_enable_bit_i)
                    begin
                        hold_q <= 1'b1;
                    end
                    else if (half_end)
                    begin
                        sck_q   <= 1'b1;
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_end)
                    begin
                        sck_q <= 1'b0;
                        case (mode_q)
                            LANE_QUAD: sh_q <= {sh_q[3:0], io_sync_q};
                            LANE_DUAL: sh_q <= {sh_q[5:0], io_sync_q[1:0]};
                            default:   sh_q <= {sh_q[6:0], io_sync_q[1]};
                        endcase
                        if (left_q != 3'h0)
                        begin
                            left_q  <= left_q - 3'h1;
                            state_q <= H_LOW;
                        end
                        else
                        begin
                            rx_valid_o <= read_q;
                            case (mode_q)
                                LANE_QUAD: rx_data_o <= {sh_q[3:0], io_sync_q};
                                LANE_DUAL: rx_data_o <= {sh_q[5:0], io_sync_q[1:0]};
                                default:   rx_data_o <= {sh_q[6:0], io_sync_q[1]};
                            endcase
                            state_q <= last_q ? H_TRAIL : H_WAIT;
                        end
                    end
                end
                H_WAIT:
                begin
                    if (take)
                    begin
                        state_q <= H_LOW;
                    end
                end
                H_TRAIL:
                begin
                    if (half_end)
                    begin
                        cs_n_q  <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default:
                begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    logic [3:0] pin_o_q, pin_oe_q;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            xfer_ready_o <= 1'b0;
            busy_o       <= 1'b0;
            pin_o_q      <= LANES_RST;
            pin_oe_q     <= LANES_RST;
        end
        else
        begin
            xfer_ready_o <= !take && (state_q == H_IDLE || state_q == H_WAIT);
            busy_o       <= !cs_n_q;
            pin_o_q[0]   <= !read_q && sh_q[7];
            // Lane 0 let go between bytes so a device read can take it
            pin_oe_q[0]  <= !cs_n_q && !(read_q && mode_q != LANE_SINGLE)
                && state_q != H_WAIT && state_q != H_TRAIL
                && !(state_q == H_HIGH && half_end && left_q == 3'h0);
            pin_o_q[1]   <= 1'b0;
            pin_oe_q[1]  <= 1'b0;
            pin_o_q[2]   <= wp_level_i;
            pin_oe_q[2]  <= !quad_enable_bit_i;
            pin_o_q[3]   <= !hold_q;
            pin_oe_q[3]  <= !quad_enable_bit_i;
        end
    end

    assign link.cs_n       = cs_n_q;
    assign link.sck        = sck_q;
    assign link.host_io_o  = pin_o_q;
    assign link.host_io_oe = pin_oe_q;

endmodule

// *** flash_pin_if.sv ***
// Pin bundle between flash controller and flash device.
// Unused lanes float high through an implied pull-up.
`timescale 1ns/100ps
interface flash_pin_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io_o;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_o;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // Wire level: device driver, else host driver, else pull-up
    assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o) | (~dev_io_oe & ~host_io_oe);

    modport device (input cs_n, input sck, input io, output dev_io_o, output dev_io_oe);
    modport host (output cs_n, output sck, output host_io_o, output host_io_oe, input io);
endinterface

// *** flash_pin_pkg.sv ***
// Shared types and constants for the serial flash pin front end.
// Assumes a 10 MHz system clock on both ends.
package flash_pin_pkg;

    // ************************************************
    // Types
    // ************************************************
    typedef enum logic [1:0]
    {
        LANE_SINGLE = 2'b00,
        LANE_DUAL   = 2'b01,
        LANE_QUAD   = 2'b10
    } lane_mode_t;

    typedef enum logic [2:0]
    {
        H_IDLE  = 3'b000,
        H_LEAD  = 3'b001,
        H_LOW   = 3'b010,
        H_HIGH  = 3'b011,
        H_WAIT  = 3'b100,
        H_TRAIL = 3'b101
    } host_state_t;

    // ************************************************
    // Constants
    // ************************************************
    localparam int unsigned SYS_CLK_HZ   = 10_000_000;
    localparam int unsigned SCK_HZ       = 2_500_000;
    localparam int unsigned SCK_HALF_CYC = SYS_CLK_HZ / (2 * SCK_HZ);
    localparam logic [2:0]  HALF_LAST    = 3'(SCK_HALF_CYC - 1);
    localparam logic [1:0]  SP_PIN_LOCK  = 2'b01;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [3:0]  LANES_RST    = 4'h0;

endpackage

// *** serial_flash_pin_interface_props.sv ***
// Checker for the pin link between the host and device ends.
// Takes the interface signals; everything is sampled on clk_sys_i.
`timescale 1ns/100ps
module serial_flash_pin_interface_props
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [3:0] host_io_o,
    input  wire logic [3:0] host_io_oe,
    input  wire logic [3:0] dev_io_o,
    input  wire logic [3:0] dev_io_oe
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_desel_tristate; cs_n |-> dev_io_oe == 4'h0; endproperty
    a_desel_tristate: assert property (p_desel_tristate) else $error("device drives while deselected");
    property p_no_clash; !cs_n |-> (host_io_oe & dev_io_oe) == 4'h0; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive one lane");
    property p_launch; !cs_n && $past(!cs_n) && $changed(dev_io_o) |-> $fell(sck); endproperty
    a_launch: assert property (p_launch) else $error("device data moved off a falling edge");
    property p_oe_on; $rose(|dev_io_oe) |-> $fell(sck); endproperty
    a_oe_on: assert property (p_oe_on) else $error("device drive began off a falling edge");
    property p_in_stable; $rose(sck) |-> $stable(host_io_o[0]) && $stable(host_io_oe[0]); endproperty
    a_in_stable: assert property (p_in_stable) else $error("lane 0 moved at the sampling edge");
    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("serial clock high outside a frame");
    property p_high; $rose(sck) |=> sck ##1 !sck; endproperty
    a_high: assert property (p_high) else $error("serial clock high phase wrong");
    property p_low; $fell(sck) |=> !sck; endproperty
    a_low: assert property (p_low) else $error("serial clock low phase too short");
    property p_sel_edge; $fell(cs_n) |-> !sck && $past(!sck); endproperty
    a_sel_edge: assert property (p_sel_edge) else $error("select fell with clock high");
endmodule

// *** test_serial_flash_pin_interface.sv ***
// Testbench joining host and device ends through the pin interface.
// Random bytes from a fixed seed; expectations kept in the bench.
`timescale 1ns/100ps
module test_serial_flash_pin_interface;
    import flash_pin_pkg::*;
    logic       clk_sys_i = 1'b0, rst_i = 1'b0, busy = 1'b0, qe = 1'b0, sp_hi = 1'b0, sp_lo = 1'b0;
    logic       tx_valid = 1'b0, wp = 1'b1, hold = 1'b0, xv = 1'b0, xr = 1'b0, xl = 1'b0;
    logic [7:0] tx_data = 8'h00, xd = 8'h00, d_rd, h_rd, b, c, r;
    lane_mode_t tx_mode = LANE_SINGLE, xm = LANE_SINGLE;
    logic       tx_ready, d_rv, sel, pwr, cmd_en, st_ok, x_ready, h_rv, h_busy;
    int         miscompares = 0, n_compared = 0, seed = 32'h4297;
    logic [7:0] exp_q[$];
    logic [4:0] st[4] = '{5'b00100, 5'b00111, 5'b00001, 5'b01101};
    lane_mode_t modes[3] = '{LANE_SINGLE, LANE_DUAL, LANE_QUAD};

    flash_pin_if link();
    flash_pin_device i_flash_pin_device(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link), .busy_i(busy),
        .quad_enable_bit_i(qe), .status_protect_bit_hi_i(sp_hi), .status_protect_bit_lo_i(sp_lo),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_mode_i(tx_mode), .tx_ready_o(tx_ready),
        .rx_valid_o(d_rv), .rx_data_o(d_rd), .selected_o(sel), .power_active_o(pwr),
        .cmd_enabled_o(cmd_en), .status_write_ok_o(st_ok));
    flash_pin_host i_flash_pin_host(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link), .quad_enable_bit_i(qe),
        .wp_level_i(wp), .hold_i(hold), .xfer_valid_i(xv), .xfer_data_i(xd), .xfer_read_i(xr),
        .xfer_mode_i(xm), .xfer_last_i(xl), .xfer_ready_o(x_ready), .rx_valid_o(h_rv), .rx_data_o(h_rd),
        .busy_o(h_busy));
    serial_flash_pin_interface_props i_props(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n(link.cs_n),
        .sck(link.sck), .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe), .dev_io_o(link.dev_io_o),
        .dev_io_oe(link.dev_io_oe));

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One byte through the host user port; read data returned in got
    task automatic hx(input logic [7:0] d, input logic rd, input lane_mode_t m, input logic last,
                      output logic [7:0] got);
        int n = 0;
        @(posedge clk_sys_i);
        xv <= 1'b1; xd <= d; xr <= rd; xm <= m; xl <= last;
        do @(posedge clk_sys_i); while (x_ready !== 1'b1 && ++n < 400);
        xv <= 1'b0;
        miscompares += (n >= 400);
        got = h_rd;
        n = 0;
        if (rd)
            do @(posedge clk_sys_i); while (h_rv !== 1'b1 && ++n < 400);
        miscompares += (n >= 400);
        got = h_rd;
        n = 0;
        if (last)
            do @(posedge clk_sys_i); while (h_busy !== 1'b0 && ++n < 400);
        miscompares += (n >= 400);
    endtask

    task automatic dtx(input logic [7:0] d, input lane_mode_t m);
        int n = 0;
        @(posedge clk_sys_i);
        tx_valid <= 1'b1; tx_data <= d; tx_mode <= m;
        do @(posedge clk_sys_i); while (tx_ready !== 1'b1 && ++n < 400);
        tx_valid <= 1'b0;
        miscompares += (n >= 400);
    endtask

    // ************************************************
    // Clock, monitor, watchdog, sequence
    // ************************************************
    initial forever #50 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i)
        if (d_rv === 1'b1)
            chk("device rx", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, d_rd);

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        complete_run;
    end

    initial
    begin
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("cmd enabled", 8'h00, {7'h0, cmd_en});
        chk("power", 8'h00, {7'h0, pwr});
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 8'h00 : (i == 5) ? 8'hff : 8'($random(seed));
            exp_q.push_back(b);
            if (i == 2)
                fork
                    begin
                        repeat (10) @(posedge clk_sys_i); hold <= 1'b1;
                        repeat (30) @(posedge clk_sys_i); hold <= 1'b0;
                    end
                join_none
            hx(b, 1'b0, LANE_SINGLE, i == 5, r);
            if (i == 1)
                chk("power", 8'h01, {7'h0, pwr});
        end
        chk("cmd enabled", 8'h01, {7'h0, cmd_en});
        repeat (8) @(posedge clk_sys_i);
        chk("power", 8'h00, {7'h0, pwr});
        chk("selected", 8'h00, {7'h0, sel});
        busy <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("power", 8'h01, {7'h0, pwr});
        busy <= 1'b0;
        foreach (st[k])
        begin
            {qe, sp_hi, sp_lo, wp} <= st[k][4:1];
            repeat (12) @(posedge clk_sys_i);
            chk("status ok", {7'h0, st[k][0]}, {7'h0, st_ok});
        end
        foreach (modes[k])
        begin
            qe <= (modes[k] == LANE_QUAD);
            repeat (8) @(posedge clk_sys_i);
            b = 8'($random(seed));
            c = 8'($random(seed));
            dtx(b, modes[k]);
            exp_q.push_back(c);
            hx(c, 1'b0, LANE_SINGLE, 1'b0, r);
            if (modes[k] == LANE_SINGLE)
                exp_q.push_back(8'h00);
            hx(8'h00, 1'b1, modes[k], 1'b1, r);
            chk("host rx", b, r);
        end
        repeat (20) @(posedge clk_sys_i);
        chk("rx bytes left", 8'h00, 8'(exp_q.size()));
        complete_run;
    end
endmodule
